// ### verilog/loc_pkg.sv
// shared constants and types for the open-loop and calibration config block
package loc_pkg;
  localparam logic [7:0] CAL_DUR_OFS = 8'h2A;
  localparam logic [7:0] FB_CTRL_OFS = 8'h2C;
  localparam logic [7:0] PER_UP_OFS = 8'h2E;
  localparam logic [7:0] PER_LO_OFS = 8'h2F;
  localparam int CAL_DUR_LSB = 0;
  localparam int FB_EN_BIT = 7;
  localparam int FB_CNT_LSB = 5;
  localparam int SHAPE_BIT = 0;
  localparam int PER_UP_LSB = 0;
  localparam logic [1:0] CAL_DUR_RST = 2'h2;
  localparam logic FB_EN_RST = 1'b0;
  localparam logic [1:0] FB_CNT_RST = 2'h0;
  localparam logic SHAPE_RST = 1'b0;
  localparam logic [9:0] PER_RST = 10'h0C6;
  localparam logic [1:0] CAL_TRIG_CODE = 2'h3;
  localparam logic [2:0] FB_ATTEMPT_BASE = 3'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] CAL_MS_0 = 10'd250;
  localparam logic [9:0] CAL_MS_1 = 10'd500;
  localparam logic [9:0] CAL_MS_2 = 10'd1000;
  localparam logic [9:0] MEAS_MS = 10'd4;
  localparam int OL_UNIT_PS = 24615000;
  localparam int OL_UNIT_CYCLES_I = OL_UNIT_PS / (CLK_PERIOD_NS * 1000);
  localparam logic [8:0] OL_UNIT_CYCLES = OL_UNIT_CYCLES_I[8:0];
  typedef enum logic [2:0] {
    CAL_IDLE = 3'h0,
    CAL_TIMED = 3'h1,
    CAL_HOLD = 3'h2,
    CAL_MEAS = 3'h3
  } loc_cal_state_t;
endpackage

// ### verilog/loc_cal_if.sv
// link between the register top and the calibration timer
`timescale 1ns/100ps
interface loc_cal_if;
  logic start;
  logic cancel;
  logic [1:0] dur_code;
  logic busy;
  logic done;
  logic meas;
  modport ctrl (output start, output cancel, output dur_code, input busy, input done, input meas);
  modport timer (input start, input cancel, input dur_code, output busy, output done, output meas);
endinterface

// ### verilog/loc_cal_timer.sv
// calibration duration timer with trigger-held mode and measurement tail
`timescale 1ns/100ps
module loc_cal_timer #(
  parameter int MS_CYCLES = loc_pkg::MS_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  loc_cal_if.timer cal
);
  import loc_pkg::*;
  typedef struct packed {
    loc_cal_state_t state;
    logic [14:0] div;
    logic [9:0] ms;
    logic busy;
    logic done;
    logic meas;
  } loc_cal_st_t;
  loc_cal_st_t s_q, s_d;
  logic tick;
  logic [9:0] lim;

  assign tick = (s_q.div == 15'(MS_CYCLES - 1));

  always_comb begin
    case (cal.dur_code)
      2'h0: lim = CAL_MS_0;
      2'h1: lim = CAL_MS_1;
      default: lim = CAL_MS_2;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.state == CAL_IDLE || tick) begin
      s_d.div = 15'h0000;
    end else begin
      s_d.div = s_q.div + 15'h0001;
    end
    case (s_q.state)
      CAL_IDLE: begin
        s_d.ms = 10'h000;
        if (cal.start) begin
          // held mode ends only on a cancel, never on time
          s_d.state = (cal.dur_code == CAL_TRIG_CODE) ? CAL_HOLD : CAL_TIMED;
        end
      end
      CAL_TIMED: begin
        if (tick) begin
          s_d.ms = s_q.ms + 10'h001;
          if (s_q.ms == lim - 10'h001) begin
            s_d.state = CAL_MEAS;
            s_d.ms = 10'h000;
          end
        end
      end
      CAL_HOLD: begin
        s_d.div = 15'h0000;
        if (cal.cancel) begin
          s_d.state = CAL_MEAS;
        end
      end
      CAL_MEAS: begin
        if (tick) begin
          s_d.ms = s_q.ms + 10'h001;
          if (s_q.ms == MEAS_MS - 10'h001) begin
            s_d.state = CAL_IDLE;
            s_d.done = 1'b1;
            s_d.ms = 10'h000;
          end
        end
      end
      default: begin
        s_d.state = CAL_IDLE;
      end
    endcase
    s_d.busy = (s_d.state != CAL_IDLE);
    s_d.meas = (s_d.state == CAL_MEAS);
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '{state: CAL_IDLE, div: 15'h0000, ms: 10'h000, busy: 1'b0, done: 1'b0, meas: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cal.busy = s_q.busy;
  assign cal.done = s_q.done;
  assign cal.meas = s_q.meas;

  chk_hold_waits: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.state == CAL_HOLD && !cal.cancel |=> s_q.state == CAL_HOLD)
    else $error("held calibration ended without cancel");
  chk_timed_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.state == CAL_TIMED && s_d.state == CAL_MEAS |-> tick && s_q.ms == lim - 10'h001)
    else $error("timed calibration left at wrong count");
  chk_meas_tail: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.state == CAL_HOLD && cal.cancel |=> s_q.meas ##1 s_q.meas)
    else $error("cancel not followed by measurement");
  chk_done_src: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.done |-> $past(s_q.state) == CAL_MEAS && s_q.state == CAL_IDLE)
    else $error("done without measurement");
  cov_hold_cancel: cover property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.state == CAL_HOLD ##1 s_q.state == CAL_MEAS);
  cov_cal_done: cover property (@(posedge clk_in) disable iff (!rstn_in) s_q.done);
endmodule

// ### verilog/loc_top.sv
// open-loop fallback, waveform and calibration-duration configuration block
// Notes on behaviour
// - duration code 0,1,2 runs calibration for 250, 500, 1000 ms
// - code 3 calibrates until external trigger, enable or software trigger cancels
// - after cancel, measurements run several more milliseconds before completion
// - fallback enable bit 7 switches to open loop after missed zero crossings
// - open loop entered by fallback always drives square, ignoring shape select
// - attempt count field codes 0..3 select 3..6 failed attempts
// - in open loop, shape bit 0 selects square (0) or sine (1)
// - open-loop period is period value times 24.615 us, reset value 198
// - period bits 9:8 sit in bits 1:0 of the upper period register
`timescale 1ns/100ps
module loc_top #(
  parameter int MS_CYCLES = loc_pkg::MS_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic CAL_START_IN,
  input wire logic EXT_TRIG_IN,
  input wire logic ENABLE_IN,
  input wire logic SW_TRIG_IN,
  input wire logic DRIVE_ACTIVE_IN,
  input wire logic OPEN_LOOP_REQ_IN,
  input wire logic ZC_OK_IN,
  input wire logic ZC_MISS_IN,
  output logic CAL_BUSY_OUT,
  output logic CAL_DONE_OUT,
  output logic CAL_MEAS_OUT,
  output logic OPEN_LOOP_OUT,
  output logic FALLBACK_FLAG_OUT,
  output logic SINE_SEL_OUT,
  output logic OL_PERIOD_TICK_OUT,
  output logic OL_PHASE_OUT
);
  import loc_pkg::*;
  typedef struct packed {
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic en_prev;
    logic [1:0] cal_dur;
    logic fb_en;
    logic [1:0] fb_cnt;
    logic shape;
    logic [9:0] period;
    logic [7:0] rdata;
    logic [2:0] miss;
    logic fb_flag;
    logic open_loop;
    logic sine;
    logic [8:0] unit_div;
    logic [9:0] per_cnt;
    logic per_tick;
    logic phase;
  } loc_st_t;
  loc_st_t s_q, s_d;
  logic [2:0] fb_limit;
  logic cancel;
  logic unit_wrap;
  loc_cal_if cal_ifc();

  loc_cal_timer #(.MS_CYCLES(MS_CYCLES)) u_cal (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .cal(cal_ifc)
  );

  assign fb_limit = FB_ATTEMPT_BASE + {1'b0, s_q.fb_cnt};
  // edges only from the second and third stages, the first stays private
  assign cancel = (s_q.trig_s2 && !s_q.trig_s3) || (ENABLE_IN && !s_q.en_prev) || SW_TRIG_IN;
  assign unit_wrap = (s_q.unit_div == OL_UNIT_CYCLES - 9'h001);
  assign cal_ifc.start = CAL_START_IN;
  assign cal_ifc.cancel = cancel;
  assign cal_ifc.dur_code = s_q.cal_dur;

  always_comb begin
    s_d = s_q;
    s_d.trig_s1 = EXT_TRIG_IN;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    s_d.en_prev = ENABLE_IN;
    s_d.per_tick = 1'b0;
    // reserved bits are not stored, so they always read back as zero
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        CAL_DUR_OFS: s_d.cal_dur = REG_WDATA_IN[CAL_DUR_LSB +: 2];
        FB_CTRL_OFS: begin
          s_d.fb_en = REG_WDATA_IN[FB_EN_BIT];
          s_d.fb_cnt = REG_WDATA_IN[FB_CNT_LSB +: 2];
          s_d.shape = REG_WDATA_IN[SHAPE_BIT];
        end
        PER_UP_OFS: s_d.period[9:8] = REG_WDATA_IN[PER_UP_LSB +: 2];
        PER_LO_OFS: s_d.period[7:0] = REG_WDATA_IN;
        default: begin
        end
      endcase
    end
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        CAL_DUR_OFS: s_d.rdata = {6'h00, s_q.cal_dur};
        FB_CTRL_OFS: s_d.rdata = {s_q.fb_en, s_q.fb_cnt, 4'h0, s_q.shape};
        PER_UP_OFS: s_d.rdata = {6'h00, s_q.period[9:8]};
        PER_LO_OFS: s_d.rdata = s_q.period[7:0];
        default: s_d.rdata = 8'h00;
      endcase
    end
    // miss counting; a miss in the same cycle as a good crossing still counts
    if (!DRIVE_ACTIVE_IN) begin
      s_d.miss = 3'h0;
      s_d.fb_flag = 1'b0;
    end else if (s_q.fb_en && !s_q.fb_flag) begin
      if (ZC_MISS_IN) begin
        if (s_q.miss + 3'h1 >= fb_limit) begin
          s_d.fb_flag = 1'b1;
          s_d.miss = 3'h0;
        end else begin
          s_d.miss = s_q.miss + 3'h1;
        end
      end else if (ZC_OK_IN) begin
        s_d.miss = 3'h0;
      end
    end else if (!s_q.fb_en) begin
      s_d.miss = 3'h0;
    end
    s_d.open_loop = OPEN_LOOP_REQ_IN || s_d.fb_flag;
    s_d.sine = s_d.open_loop && s_d.shape && !s_d.fb_flag;
    // period timebase: unit of whole cycles, period counted in units
    if (!s_q.open_loop || s_q.period == 10'h000) begin
      s_d.unit_div = 9'h000;
      s_d.per_cnt = 10'h000;
      s_d.phase = 1'b0;
    end else begin
      s_d.unit_div = unit_wrap ? 9'h000 : s_q.unit_div + 9'h001;
      if (unit_wrap) begin
        if (s_q.per_cnt >= s_q.period - 10'h001) begin
          s_d.per_cnt = 10'h000;
          s_d.per_tick = 1'b1;
        end else begin
          s_d.per_cnt = s_q.per_cnt + 10'h001;
        end
      end
      s_d.phase = (s_d.per_cnt < {1'b0, s_q.period[9:1]});
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      s_q <= '{trig_s1: 1'b0, trig_s2: 1'b0, trig_s3: 1'b0, en_prev: 1'b0,
        cal_dur: CAL_DUR_RST, fb_en: FB_EN_RST, fb_cnt: FB_CNT_RST, shape: SHAPE_RST,
        period: PER_RST, rdata: 8'h00, miss: 3'h0, fb_flag: 1'b0, open_loop: 1'b0,
        sine: 1'b0, unit_div: 9'h000, per_cnt: 10'h000, per_tick: 1'b0, phase: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_OUT = s_q.rdata;
  assign CAL_BUSY_OUT = cal_ifc.busy;
  assign CAL_DONE_OUT = cal_ifc.done;
  assign CAL_MEAS_OUT = cal_ifc.meas;
  assign OPEN_LOOP_OUT = s_q.open_loop;
  assign FALLBACK_FLAG_OUT = s_q.fb_flag;
  assign SINE_SEL_OUT = s_q.sine;
  assign OL_PERIOD_TICK_OUT = s_q.per_tick;
  assign OL_PHASE_OUT = s_q.phase;

  // helper: cycles between period ticks while setup stays constant
  logic [19:0] gap_q;
  logic gap_ok_q;
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || !s_q.open_loop || $changed(s_q.period)) begin
      gap_q <= 20'h00000;
      gap_ok_q <= 1'b0;
    end else if (s_q.per_tick) begin
      gap_q <= 20'h00001;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 20'h00001;
    end
  end

  chk_fb_square: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.fb_flag |-> s_q.open_loop && !s_q.sine)
    else $error("fallback open loop not square");
  chk_shape_sel: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.open_loop && !s_q.fb_flag |-> s_q.sine == s_q.shape)
    else $error("open-loop shape does not follow select bit");
  chk_fb_disabled: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !s_q.fb_en |=> !$rose(s_q.fb_flag))
    else $error("fallback fired while disabled");
  chk_fb_limit: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    $rose(s_q.fb_flag) |-> $past(s_q.miss) == $past(fb_limit) - 3'h1 && $past(ZC_MISS_IN))
    else $error("fallback at wrong attempt count");
  chk_period_len: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.per_tick && gap_ok_q |-> gap_q == 20'(s_q.period) * 20'(OL_UNIT_CYCLES))
    else $error("open-loop period length wrong");
  chk_upper_read: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_RD_IN && REG_ADDR_IN == PER_UP_OFS && !REG_WR_IN |=>
    REG_RDATA_OUT == {6'h00, s_q.period[9:8]})
    else $error("upper period readback wrong");
  chk_dur_write: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == CAL_DUR_OFS |=> s_q.cal_dur == $past(REG_WDATA_IN[1:0]))
    else $error("duration field not stored");
  chk_cancel_ends: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    u_cal.s_q.state == CAL_HOLD && SW_TRIG_IN |=> ##[0:1] CAL_MEAS_OUT)
    else $error("software trigger did not end held calibration");
  // register fields land on the write edge and read back on the next one
  chk_fb_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == FB_CTRL_OFS |=>
    s_q.fb_en == $past(REG_WDATA_IN[FB_EN_BIT]))
    else $error("fallback enable not stored");
  chk_cnt_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == FB_CTRL_OFS |=>
    s_q.fb_cnt == $past(REG_WDATA_IN[FB_CNT_LSB +: 2]))
    else $error("attempt count not stored");
  chk_shape_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == FB_CTRL_OFS |=>
    s_q.shape == $past(REG_WDATA_IN[SHAPE_BIT]))
    else $error("shape select not stored");
  chk_upper_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == PER_UP_OFS |=>
    s_q.period[9:8] == $past(REG_WDATA_IN[PER_UP_LSB +: 2]) && $stable(s_q.period[7:0]))
    else $error("upper period bits not stored");
  chk_lower_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_WR_IN && REG_ADDR_IN == PER_LO_OFS |=>
    s_q.period[7:0] == $past(REG_WDATA_IN) && $stable(s_q.period[9:8]))
    else $error("lower period bits not stored");
  chk_dur_read: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_RD_IN && REG_ADDR_IN == CAL_DUR_OFS && !REG_WR_IN |=>
    REG_RDATA_OUT == {6'h00, s_q.cal_dur})
    else $error("duration readback wrong");
  chk_fb_read: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    REG_RD_IN && REG_ADDR_IN == FB_CTRL_OFS && !REG_WR_IN |=>
    REG_RDATA_OUT[FB_EN_BIT] == s_q.fb_en && REG_RDATA_OUT[FB_CNT_LSB +: 2] == s_q.fb_cnt)
    else $error("fallback control readback wrong");
  chk_rd_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data changed without a read");
  // calibration start, cancel and completion seen from the top
  chk_start_busy: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_START_IN && !CAL_BUSY_OUT |=> CAL_BUSY_OUT)
    else $error("calibration start not taken");
  chk_timed_entry: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_START_IN && !CAL_BUSY_OUT && s_q.cal_dur != CAL_TRIG_CODE |=>
    u_cal.s_q.state == CAL_TIMED)
    else $error("timed code did not start timed run");
  chk_hold_entry: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_START_IN && !CAL_BUSY_OUT && s_q.cal_dur == CAL_TRIG_CODE |=>
    u_cal.s_q.state == CAL_HOLD)
    else $error("trigger code did not start held run");
  chk_sync_cancel: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.trig_s2 && !s_q.trig_s3 && u_cal.s_q.state == CAL_HOLD |=> CAL_MEAS_OUT)
    else $error("external trigger did not end held calibration");
  chk_en_cancel: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ENABLE_IN && !s_q.en_prev && u_cal.s_q.state == CAL_HOLD |=> CAL_MEAS_OUT)
    else $error("enable edge did not end held calibration");
  chk_busy_meas: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_MEAS_OUT |-> CAL_BUSY_OUT)
    else $error("measurement outside a busy run");
  chk_done_pulse: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_DONE_OUT |=> !CAL_DONE_OUT)
    else $error("done longer than one cycle");
  chk_done_idle: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CAL_DONE_OUT |-> !CAL_BUSY_OUT && !CAL_MEAS_OUT)
    else $error("done while still busy");
  // fallback counting and clearing
  chk_flag_needs: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    $rose(s_q.fb_flag) |-> $past(s_q.fb_en) && $past(DRIVE_ACTIVE_IN))
    else $error("fallback rose while disabled or idle");
  chk_flag_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.fb_flag && DRIVE_ACTIVE_IN |=> s_q.fb_flag)
    else $error("fallback dropped while drive active");
  chk_flag_clear: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !DRIVE_ACTIVE_IN |=> !s_q.fb_flag && s_q.miss == 3'h0)
    else $error("fallback not cleared by idle drive");
  chk_miss_step: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.fb_en && !s_q.fb_flag && DRIVE_ACTIVE_IN && ZC_MISS_IN && s_q.miss + 3'h1 < fb_limit
    |=> s_q.miss == $past(s_q.miss) + 3'h1)
    else $error("missed crossing not counted");
  chk_miss_reset: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.fb_en && !s_q.fb_flag && DRIVE_ACTIVE_IN && ZC_OK_IN && !ZC_MISS_IN |=>
    s_q.miss == 3'h0)
    else $error("good crossing did not clear misses");
  chk_req_open: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    OPEN_LOOP_REQ_IN |=> s_q.open_loop)
    else $error("open-loop request not followed");
  chk_sine_gate: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.sine |-> s_q.open_loop && s_q.shape && !s_q.fb_flag)
    else $error("sine selected outside open loop");
  // period timebase stays parked outside open loop
  chk_tick_ol: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.per_tick |-> $past(s_q.open_loop))
    else $error("period tick outside open loop");
  chk_idle_quiet: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !s_q.open_loop |=> !s_q.phase && !s_q.per_tick && s_q.per_cnt == 10'h000)
    else $error("timebase running outside open loop");
  chk_unit_bound: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_q.unit_div < OL_UNIT_CYCLES)
    else $error("unit divider past its wrap");
  cov_fb_rose: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN) $rose(s_q.fb_flag));
  cov_per_tick: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN) s_q.per_tick && gap_ok_q);
  cov_sine: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN) s_q.sine);
endmodule

// ### bench/loc_host.sv
// host model: register strobes, calibration start and cancel pins
`timescale 1ns/100ps
module loc_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic start_out,
  output logic ext_trig_out,
  output logic enable_out,
  output logic sw_trig_out
);
  initial begin
    {addr_out, wdata_out, wr_out, rd_out} = '0;
    {start_out, ext_trig_out, enable_out, sw_trig_out} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  task automatic start;
    @(posedge clk_in);
    start_out <= 1'b1;
    @(posedge clk_in);
    start_out <= 1'b0;
  endtask
  // async pin held a few cycles so the synchroniser sees it
  task automatic cancel(input int src);
    @(posedge clk_in);
    if (src == 0) ext_trig_out <= 1'b1;
    else if (src == 1) enable_out <= 1'b1;
    else sw_trig_out <= 1'b1;
    @(posedge clk_in);
    sw_trig_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    ext_trig_out <= 1'b0;
    enable_out <= 1'b0;
  endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the open-loop and calibration config block
`timescale 1ns/100ps
module testbench;
  import loc_pkg::*;
  localparam int MS = 10;
  logic clk, rstn, drv, olr, zok, zmiss, wr, rd, st, et, en, sw;
  logic [7:0] addr, wd, rdat, r8, cal_m, fb_m, pu_m, pl_m;
  logic busy, done, meas, ol, flag, sine, tick, phase, bz, mz;
  int fail_count, checked, cyc, t_busy, t_meas, t_done, t_tick, t_int, ph_n, ph_last, done_n;
  int seed, c0, ms_tab[3];
  logic [7:0] tbl[5];
  loc_top #(.MS_CYCLES(MS)) u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
    .CAL_START_IN(st), .EXT_TRIG_IN(et), .ENABLE_IN(en), .SW_TRIG_IN(sw),
    .DRIVE_ACTIVE_IN(drv), .OPEN_LOOP_REQ_IN(olr), .ZC_OK_IN(zok), .ZC_MISS_IN(zmiss),
    .CAL_BUSY_OUT(busy), .CAL_DONE_OUT(done), .CAL_MEAS_OUT(meas), .OPEN_LOOP_OUT(ol),
    .FALLBACK_FLAG_OUT(flag), .SINE_SEL_OUT(sine), .OL_PERIOD_TICK_OUT(tick),
    .OL_PHASE_OUT(phase));
  loc_host host (.clk_in(clk), .rdata_in(rdat), .addr_out(addr), .wdata_out(wd),
    .wr_out(wr), .rd_out(rd), .start_out(st), .ext_trig_out(et), .enable_out(en),
    .sw_trig_out(sw));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // monitor on the falling edge, away from register updates
  always @(negedge clk) begin
    cyc++;
    if (busy && !bz) t_busy = cyc;
    if (meas && !mz) t_meas = cyc;
    if (done) begin
      t_done = cyc;
      done_n++;
    end
    if (tick) begin
      t_int = cyc - t_tick;
      t_tick = cyc;
      ph_last = ph_n;
      ph_n = 0;
    end else if (phase) ph_n++;
    bz = busy;
    mz = meas;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic near(input string n, input int e, input int g);
    chk(n, e, (g >= e - 1 && g <= e + 1) ? e : g);
  endtask
  function automatic logic [7:0] mdl(input logic [7:0] a);
    case (a)
      8'h2A: return cal_m;
      8'h2C: return fb_m;
      8'h2E: return pu_m;
      8'h2F: return pl_m;
      default: return 8'h00;
    endcase
  endfunction
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      8'h2A: cal_m = d & 8'h03;
      8'h2C: fb_m = d & 8'hE1;
      8'h2E: pu_m = d & 8'h03;
      8'h2F: pl_m = d;
      default: ;
    endcase
  endtask
  task automatic mrd(input logic [7:0] a);
    logic [7:0] d;
    host.rd(a, d);
    chk("rdata", {24'h0, mdl(a)}, {24'h0, d});
  endtask
  task automatic wait_done(input int lim);
    int n0;
    n0 = done_n;
    for (int i = 0; i < lim && done_n == n0; i++) @(posedge clk);
    @(negedge clk);
    chk("done_seen", 1, done_n != n0);
    chk("busy_off", 0, busy);
  endtask
  task automatic zc(input logic ok, input int n);
    repeat (n) begin
      @(posedge clk);
      zok <= ok;
      zmiss <= !ok;
      @(posedge clk);
      zok <= 1'b0;
      zmiss <= 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    conclude;
  end
  initial begin
    {rstn, drv, olr, zok, zmiss} = '0;
    {cal_m, fb_m, pu_m, pl_m} = {8'h02, 8'h00, 8'h00, 8'hC6};
    seed = 40194;
    ms_tab = '{250, 500, 1000};
    tbl = '{8'h2A, 8'h2C, 8'h2E, 8'h2F, 8'h2B};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) mrd(tbl[i]);
    for (int i = 0; i < 15; i++) begin
      r8 = 8'($random(seed));
      mwr(tbl[i % 5], r8);
      mrd(tbl[i % 5]);
    end
    for (int c = 0; c < 3; c++) begin
      mwr(8'h2A, 8'(c));
      host.start;
      if (c == 0) host.start;
      wait_done(1100 * MS);
      near("cal_len", ms_tab[c] * MS, t_meas - t_busy);
      near("meas_len", 4 * MS, t_done - t_meas);
    end
    mwr(8'h2A, 8'h03);
    for (int s = 0; s < 3; s++) begin
      host.start;
      repeat (1000 * MS) @(posedge clk);
      @(negedge clk);
      chk("held_busy", 1, busy);
      c0 = cyc;
      host.cancel(s);
      wait_done(6 * MS);
      chk("cancel_lat", 1, t_meas > c0 && t_meas - c0 <= 6);
      near("meas_len", 4 * MS, t_done - t_meas);
    end
    mwr(8'h2F, 8'h02);
    mwr(8'h2E, 8'h00);
    olr <= 1'b1;
    repeat (2100) @(posedge clk);
    near("period", 984, t_int);
    near("phase", 492, ph_last);
    for (int s = 1; s >= 0; s--) begin
      mwr(8'h2C, 8'(s));
      repeat (2) @(negedge clk);
      chk("sine", s, sine);
    end
    @(posedge clk);
    olr <= 1'b0;
    drv <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      mwr(8'h2C, 8'h81 | 8'(c << 5));
      zc(1'b0, c + 2);
      zc(1'b1, 1);
      zc(1'b0, c + 2);
      chk("flag_early", 0, flag);
      zc(1'b0, 1);
      chk("flag", 1, flag);
      chk("open_loop", 1, ol);
      chk("fb_square", 0, sine);
      @(posedge clk);
      drv <= 1'b0;
      repeat (2) @(negedge clk);
      chk("flag_clr", 0, flag);
      @(posedge clk);
      drv <= 1'b1;
    end
    mwr(8'h2C, 8'h00);
    zc(1'b0, 8);
    chk("fb_off", 0, flag);
    conclude;
  end
endmodule
